// *** src/ccu_params.svh ***
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH
// register byte offsets on the bus
`define CCU_OFF_CTRL 8'h00
`define CCU_OFF_CAPSEL 8'h04
`define CCU_OFF_VALL 8'h08
`define CCU_OFF_VALH 8'h0C
`define CCU_OFF_IRQ 8'h10
// field positions
`define CCU_CTRL_EN_BIT 7
`define CCU_CTRL_OD_BIT 4
`define CCU_IRQ_FLAG_BIT 0
`define CCU_IRQ_IEN_BIT 1
// reset values
`define CCU_CTRL_RST 8'h00
`define CCU_CAPSEL_RST 2'h0
`define CCU_VAL_RST 16'h0000
// prescaler terminal counts
`define CCU_PRE4_LAST 4'h3
`define CCU_PRE16_LAST 4'hF
`endif

// *** src/ccu_pkg.sv ***
package ccu_pkg;
  // mode field encodings
  typedef enum logic [3:0] {
    CCU_OFF = 4'h0,
    CCU_CMP_TGL_CLR = 4'h1,
    CCU_CMP_TGL = 4'h2,
    CCU_CAP_ANY = 4'h3,
    CCU_CAP_FALL = 4'h4,
    CCU_CAP_RISE = 4'h5,
    CCU_CAP_R4 = 4'h6,
    CCU_CAP_R16 = 4'h7,
    CCU_CMP_SET = 4'h8,
    CCU_CMP_CLR = 4'h9,
    CCU_CMP_PULSE = 4'hA,
    CCU_CMP_PULSE_CLR = 4'hB,
    CCU_PWM0 = 4'hC,
    CCU_PWM1 = 4'hD,
    CCU_PWM2 = 4'hE,
    CCU_PWM3 = 4'hF
  } ccu_mode_t;

  // capture modes are the five edge selections
  function automatic logic ccu_is_cap(input ccu_mode_t m);
    return (m >= CCU_CAP_ANY) && (m <= CCU_CAP_R16);
  endfunction

  function automatic logic ccu_is_cmp(input ccu_mode_t m);
    return (m == CCU_CMP_TGL_CLR) || (m == CCU_CMP_TGL) ||
           ((m >= CCU_CMP_SET) && (m <= CCU_CMP_PULSE_CLR));
  endfunction
endpackage

// *** src/ccu_edge_pre.sv ***
`timescale 1ns/1ps
`include "ccu_params.svh"
module ccu_edge_pre
  import ccu_pkg::*;
#(
  parameter int CW = 4
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // sync reset, active high
  input wire logic clr, // hold prescaler at zero
  input wire logic lvl, // selected capture level
  input wire ccu_mode_t mode, // current mode field
  output logic ev // qualifying capture event
);
  logic lvl_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  wire rise = lvl & ~lvl_q;
  wire fall = ~lvl & lvl_q;

  // event selection per edge mode
  always_comb begin
    case (mode)
      CCU_CAP_ANY: ev = rise | fall;
      CCU_CAP_FALL: ev = fall;
      CCU_CAP_RISE: ev = rise;
      CCU_CAP_R4: ev = rise && (cnt_q[1:0] == 2'(`CCU_PRE4_LAST));
      CCU_CAP_R16: ev = rise && (cnt_q == `CCU_PRE16_LAST);
      default: ev = 1'b0;
    endcase
  end

  // ratio change keeps the count, so a switch may fire early
  assign cnt_d = clr ? '0 : (rise ? cnt_q + 1'b1 : cnt_q);

  // level history always tracks, even when off
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lvl_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      lvl_q <= lvl;
      cnt_q <= cnt_d;
    end
  end

  a_pre_clear_off: assert property (@(posedge clk_sys) disable iff (rst)
    clr |=> (cnt_q == '0))
    else $error("prescaler not cleared");
  a_pre_fourth_rise: assert property (@(posedge clk_sys) disable iff (rst)
    (mode == CCU_CAP_R4) && ev |=> (cnt_q[1:0] == 2'h0))
    else $error("divide by four event off");
endmodule

// *** src/ccu_top.sv ***
`timescale 1ns/1ps
`include "ccu_params.svh"
// How it works
// - capture copies full timer count into value
// - mode picks falling, rising, 4th, 16th, any
// - capture sets flag, only software clears it
// - new capture silently overwrites old value
// - source select field picks capture signal
// - pin level sampled whatever its direction
// - mode change may fake flag; software clears
// - prescaler cleared when off, non-capture, reset
// - ratio change keeps prescaler; clear control first
// - sleep capture works with external timer clock
// - compare checks value against timer count
// - match toggles, sets, clears or pulses output
// - compare sets flag; two codes reset timer
// - zero control write forces output latch low
// - output also offered to other peripherals
// - no compare in sleep unless timer runs
// - capture and compare share the one timer
// - output pin optionally open drain
// - value reachable as low and high byte
module ccu_top
  import ccu_pkg::*;
#(
  parameter int NSRC = 4
) (
  input wire logic clk_sys, // 40 MHz system clock
  input wire logic rst, // sync reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [3:0] wb_sel_i, // byte lanes
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // transfer done
  input wire logic [15:0] shared_16bit_count, // shared timer value
  input wire logic tmr_tick_i, // timer advanced this cycle
  input wire logic tmr_ext_clk_i, // timer runs from external clock
  input wire logic sleep_i, // device asleep
  input wire logic [NSRC-1:1] cap_src_i, // internal capture sources
  input wire logic pin_i, // pad level
  input wire logic pin_direction_control, // 1 = pad is input
  output logic pin_o, // pad output value
  output logic pin_oe_n, // pad enable, low drives
  output logic unit_out, // output for other peripherals
  output logic tmr_clr_o, // timer reset pulse
  output logic unit_irq_o // flag and enable, also wake
);
  localparam int SW = $clog2(NSRC);

  logic [7:0] unit_control_reg_q;
  logic [SW-1:0] capture_input_select_reg_q;
  logic [15:0] capture_compare_value_q;
  logic [15:0] capture_compare_value_d;
  logic unit_irq_flag_q;
  logic unit_irq_enable_q;
  logic out_q;
  logic out_d;
  logic pulse_q;
  logic pulse_d;
  logic eq_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_data;
  logic clr_q;
  logic irq_q;
  logic pin_o_q;
  logic oe_n_q;
  logic cap_ev;
  logic [NSRC-1:0] src_all;

  // bus decode
  wire req = wb_cyc_i & wb_stb_i;
  wire wr = req & wb_we_i & ack_q & wb_sel_i[0];
  wire wr_ctrl = wr && (wb_adr_i == `CCU_OFF_CTRL);
  wire wr_capsel = wr && (wb_adr_i == `CCU_OFF_CAPSEL);
  wire wr_vall = wr && (wb_adr_i == `CCU_OFF_VALL);
  wire wr_valh = wr && (wb_adr_i == `CCU_OFF_VALH);
  wire wr_irq = wr && (wb_adr_i == `CCU_OFF_IRQ);
  wire ctrl_zero = wr_ctrl && (wb_dat_i[7:0] == 8'h00);
  wire flag_w1c = wr_irq & wb_dat_i[`CCU_IRQ_FLAG_BIT];

  // control fields
  ccu_mode_t mode;
  assign mode = ccu_mode_t'(unit_control_reg_q[3:0]);
  wire en = unit_control_reg_q[`CCU_CTRL_EN_BIT];
  wire od = unit_control_reg_q[`CCU_CTRL_OD_BIT];
  wire cap_on = en & ccu_is_cap(mode);
  wire cmp_on = en & ccu_is_cmp(mode);

  // timer held in sleep unless it runs from external clock
  wire run = ~sleep_i | tmr_ext_clk_i;

  // pad level is read regardless of direction
  assign src_all = {cap_src_i, pin_i};
  wire src_lvl = src_all[capture_input_select_reg_q];

  ccu_edge_pre #(
    .CW(4)
  ) u_pre (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(~cap_on),
    .lvl(src_lvl),
    .mode(mode),
    .ev(cap_ev)
  );

  wire cap_take = cap_on & cap_ev & run;

  // compare on the rising of equality so a held count fires once
  wire eq = cmp_on && (capture_compare_value_q == shared_16bit_count);
  wire cmp_match = eq & ~eq_q & run;
  wire tmr_reset = cmp_match &&
                   ((mode == CCU_CMP_TGL_CLR) || (mode == CCU_CMP_PULSE_CLR));

  // value: capture wins over a same-cycle byte write
  always_comb begin
    capture_compare_value_d = capture_compare_value_q;
    if (wr_vall) begin
      capture_compare_value_d[7:0] = wb_dat_i[7:0];
    end
    if (wr_valh) begin
      capture_compare_value_d[15:8] = wb_dat_i[7:0];
    end
    if (cap_take) begin
      capture_compare_value_d = shared_16bit_count;
    end
  end

  // compare output action and pulse timing
  always_comb begin
    out_d = out_q;
    pulse_d = pulse_q;
    if (pulse_q && tmr_tick_i) begin
      out_d = 1'b0;
      pulse_d = 1'b0;
    end
    if (cmp_match) begin
      case (mode)
        CCU_CMP_TGL_CLR: out_d = ~out_q;
        CCU_CMP_TGL: out_d = ~out_q;
        CCU_CMP_SET: out_d = 1'b1;
        CCU_CMP_CLR: out_d = 1'b0;
        CCU_CMP_PULSE, CCU_CMP_PULSE_CLR: begin
          out_d = 1'b1;
          pulse_d = 1'b1;
        end
        default: out_d = out_q;
      endcase
    end
    if (ctrl_zero) begin
      out_d = 1'b0;
      pulse_d = 1'b0;
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i == `CCU_OFF_CTRL) begin
      rd_data[7:0] = unit_control_reg_q;
    end else if (wb_adr_i == `CCU_OFF_CAPSEL) begin
      rd_data[SW-1:0] = capture_input_select_reg_q;
    end else if (wb_adr_i == `CCU_OFF_VALL) begin
      rd_data[7:0] = capture_compare_value_q[7:0];
    end else if (wb_adr_i == `CCU_OFF_VALH) begin
      rd_data[7:0] = capture_compare_value_q[15:8];
    end else if (wb_adr_i == `CCU_OFF_IRQ) begin
      rd_data[`CCU_IRQ_FLAG_BIT] = unit_irq_flag_q;
      rd_data[`CCU_IRQ_IEN_BIT] = unit_irq_enable_q;
    end
  end

  // bus handshake: ack one cycle after request, drop after
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        dat_q <= rd_data;
      end
    end
  end

  // software registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      unit_control_reg_q <= `CCU_CTRL_RST;
      capture_input_select_reg_q <= SW'(`CCU_CAPSEL_RST);
      unit_irq_enable_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        unit_control_reg_q <= wb_dat_i[7:0];
      end
      if (wr_capsel) begin
        capture_input_select_reg_q <= wb_dat_i[SW-1:0];
      end
      if (wr_irq) begin
        unit_irq_enable_q <= wb_dat_i[`CCU_IRQ_IEN_BIT];
      end
    end
  end

  // sticky flag: hardware set beats software clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      unit_irq_flag_q <= 1'b0;
    end else if (cap_take | cmp_match) begin
      unit_irq_flag_q <= 1'b1;
    end else if (flag_w1c) begin
      unit_irq_flag_q <= 1'b0;
    end
  end

  // core state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      capture_compare_value_q <= `CCU_VAL_RST;
      out_q <= 1'b0;
      pulse_q <= 1'b0;
      eq_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      capture_compare_value_q <= capture_compare_value_d;
      out_q <= out_d;
      pulse_q <= pulse_d;
      eq_q <= eq;
      clr_q <= tmr_reset;
    end
  end

  // pad driver: open drain only pulls low, never drives high
  wire out_mode = cmp_on | (en & (mode >= CCU_PWM0));
  wire drive = out_mode & ~pin_direction_control & (~od | ~out_q);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_o_q <= 1'b0;
      oe_n_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      pin_o_q <= od ? 1'b0 : out_q;
      oe_n_q <= ~drive;
      irq_q <= unit_irq_flag_q & unit_irq_enable_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign unit_out = out_q;
  assign tmr_clr_o = clr_q;
  assign pin_o = pin_o_q;
  assign pin_oe_n = oe_n_q;
  assign unit_irq_o = irq_q;

  a_cap_value_load: assert property (@(posedge clk_sys) disable iff (rst)
    cap_take |=> (capture_compare_value_q == $past(shared_16bit_count)))
    else $error("capture did not load timer count");

  a_cap_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    cap_take |=> unit_irq_flag_q)
    else $error("capture did not raise flag");

  a_flag_stays_set: assert property (@(posedge clk_sys) disable iff (rst)
    unit_irq_flag_q && !flag_w1c |=> unit_irq_flag_q)
    else $error("flag cleared without software");

  a_cmp_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_match |=> unit_irq_flag_q)
    else $error("match did not raise flag");

  a_tmr_reset_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_match && (mode == CCU_CMP_PULSE_CLR) |=> tmr_clr_o ##1 !tmr_clr_o)
    else $error("timer reset pulse wrong");

  a_zero_ctrl_low: assert property (@(posedge clk_sys) disable iff (rst)
    ctrl_zero |=> !unit_out ##1 !unit_out)
    else $error("zero control left output high");

  a_set_action: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_match && (mode == CCU_CMP_SET) && !ctrl_zero |=> unit_out)
    else $error("set action missed");

  a_toggle_action: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_match && (mode == CCU_CMP_TGL) && !ctrl_zero |=> unit_out != $past(unit_out))
    else $error("toggle action missed");

  a_pulse_end: assert property (@(posedge clk_sys) disable iff (rst)
    pulse_q && tmr_tick_i && !cmp_match |=> !unit_out)
    else $error("pulse longer than one timer period");

  a_sleep_no_cmp: assert property (@(posedge clk_sys) disable iff (rst)
    sleep_i && !tmr_ext_clk_i |-> !cmp_match && !cap_take)
    else $error("event acted on while timer stopped");

  a_od_no_high: assert property (@(posedge clk_sys) disable iff (rst)
    $past(od) && !pin_oe_n |-> !pin_o)
    else $error("open drain drove high");

  a_tgl_clr_reset: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_match && (mode == CCU_CMP_TGL_CLR) |=> tmr_clr_o)
    else $error("toggle match did not reset timer");

  a_keep_timer: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_match && (mode != CCU_CMP_TGL_CLR) && (mode != CCU_CMP_PULSE_CLR) |=> !tmr_clr_o)
    else $error("timer reset by a plain compare mode");

  a_clear_action: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_match && (mode == CCU_CMP_CLR) |=> !unit_out)
    else $error("clear action missed");

  a_pulse_start: assert property (@(posedge clk_sys) disable iff (rst)
    cmp_match && (mode == CCU_CMP_PULSE) && !ctrl_zero |=> unit_out)
    else $error("pulse did not start");

  a_sleep_value_hold: assert property (@(posedge clk_sys) disable iff (rst)
    sleep_i && !tmr_ext_clk_i && !wr_vall && !wr_valh |=> $stable(capture_compare_value_q))
    else $error("value changed while timer stopped");

  a_low_byte_write: assert property (@(posedge clk_sys) disable iff (rst)
    wr_vall && !cap_take |=> capture_compare_value_q[7:0] == $past(wb_dat_i[7:0]))
    else $error("low byte write lost");

  a_high_byte_write: assert property (@(posedge clk_sys) disable iff (rst)
    wr_valh && !cap_take |=> capture_compare_value_q[15:8] == $past(wb_dat_i[7:0]))
    else $error("high byte write lost");

  a_irq_follows: assert property (@(posedge clk_sys) disable iff (rst)
    unit_irq_flag_q && unit_irq_enable_q |=> unit_irq_o)
    else $error("enabled flag raised no wake");

  a_pin_released: assert property (@(posedge clk_sys) disable iff (rst)
    pin_direction_control |=> pin_oe_n)
    else $error("pad driven while set as input");
endmodule

// *** verif/ccu_timer_model.sv ***
`timescale 1ns/1ps
// shared timer on the far side of the unit, synchronous to clk_sys
module ccu_timer_model (
  input wire logic clk_sys, // system clock
  input wire logic rst, // sync reset, active high
  input wire logic run, // timer enabled
  input wire logic ld, // load pulse
  input wire logic [15:0] ld_val, // value to load
  input wire logic clr, // reset request from the unit
  input wire logic sleep_i, // device asleep
  input wire logic ext_clk, // external timer clock chosen
  output logic [15:0] count_q, // timer count
  output logic tick // advanced this cycle
);
  // instruction clock halts in sleep, an external clock keeps counting
  assign tick = run && !(sleep_i && !ext_clk);
  // one counter serves every unit; never an asynchronous counter
  always_ff @(posedge clk_sys) begin
    if (rst || clr) begin
      count_q <= 16'h0000;
    end else if (ld) begin
      count_q <= ld_val;
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end
endmodule

// *** verif/ccu_top_test.sv ***
`timescale 1ns/1ps
`include "ccu_params.svh"
module ccu_top_test;
  import ccu_pkg::*;
  typedef struct {ccu_mode_t m; int p; logic f; logic o; logic h; int c;} ccu_row_t;
  logic clk_sys = 0, rst = 1, cyc = 0, we = 0, run = 0, ld = 0, slp = 0, ext = 0;
  logic lvl = 0, hi = 0, dir = 0, ack, pin_o, oe_n, uo, tclr, irq, tick;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic [3:0] sel = 4'hF;
  logic [15:0] ldv = 16'h0000, cnt, v;
  logic [3:1] src = 3'h0;
  wire logic pin;
  int err_count = 0, checks = 0, nclr = 0;
  ccu_row_t rows[13] = '{
    '{CCU_CAP_RISE, 1, 1, 0, 0, 0}, '{CCU_CAP_FALL, 1, 1, 0, 0, 0},
    '{CCU_CAP_ANY, 1, 1, 0, 0, 0}, '{CCU_CAP_R4, 3, 0, 0, 0, 0},
    '{CCU_CAP_R4, 4, 1, 0, 0, 0}, '{CCU_CAP_R16, 15, 0, 0, 0, 0},
    '{CCU_CAP_R16, 16, 1, 0, 0, 0}, '{CCU_CMP_TGL_CLR, 0, 1, 1, 1, 1},
    '{CCU_CMP_TGL, 0, 1, 1, 1, 0}, '{CCU_CMP_SET, 0, 1, 1, 1, 0},
    '{CCU_CMP_CLR, 0, 1, 0, 0, 0}, '{CCU_CMP_PULSE, 0, 1, 0, 1, 0},
    '{CCU_CMP_PULSE_CLR, 0, 1, 0, 1, 1}};

  always #12.5 clk_sys = ~clk_sys;
  // pad wire: the unit's driver wins while enabled, else the outside level
  assign pin = oe_n ? lvl : pin_o;

  ccu_top i_ccu_top (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .shared_16bit_count(cnt), .tmr_tick_i(tick), .tmr_ext_clk_i(ext),
    .sleep_i(slp), .cap_src_i(src), .pin_i(pin), .pin_direction_control(dir),
    .pin_o(pin_o), .pin_oe_n(oe_n), .unit_out(uo), .tmr_clr_o(tclr), .unit_irq_o(irq));
  ccu_timer_model i_ccu_timer_model (.clk_sys(clk_sys), .rst(rst), .run(run), .ld(ld),
    .ld_val(ldv), .clr(tclr), .sleep_i(slp), .ext_clk(ext), .count_q(cnt), .tick(tick));

  // watch timer resets and any high phase of the unit output
  always @(posedge clk_sys) begin
    if (tclr === 1'b1) nclr++;
    if (uo === 1'b1) hi = 1;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // one classic cycle; entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      err_count++;
      wrap_up;
    end
    rdat = dat_o;
    cyc <= 0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1, a, {24'h0, d}, 4'hF);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(0, a, 32'h0, 4'hF);
  endtask

  // timer is stopped while reading, so the byte pair cannot split
  task automatic rdv;
    rd(`CCU_OFF_VALL);
    v[7:0] = rdat[7:0];
    rd(`CCU_OFF_VALH);
    v[15:8] = rdat[7:0];
  endtask

  task automatic flag(input logic e);
    rd(`CCU_OFF_IRQ);
    chk("flag", rdat & 32'h1, {31'h0, e});
  endtask

  // off first, so the prescaler is cleared; flag cleared after the change
  task automatic cfg(input logic [7:0] c);
    wr(`CCU_OFF_CTRL, 8'h00);
    wr(`CCU_OFF_CTRL, c);
    wr(`CCU_OFF_IRQ, 8'h01);
  endtask

  task automatic pulse(input int k);
    repeat (k) begin
      lvl <= 1;
      repeat (3) @(posedge clk_sys);
      lvl <= 0;
      repeat (3) @(posedge clk_sys);
    end
  endtask

  task automatic go(input logic [15:0] x);
    ldv <= x;
    ld <= 1;
    @(posedge clk_sys);
    ld <= 0;
    run <= 1;
    repeat (12) @(posedge clk_sys);
    run <= 0;
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    chk("reset pins", {ack, uo, tclr, irq, oe_n}, 5'b00001);
    rdv;
    chk("reset value", v, `CCU_VAL_RST);
    foreach (rows[i]) begin
      wr(`CCU_OFF_VALL, 8'h34);
      wr(`CCU_OFF_VALH, 8'h12);
      cfg({4'h8, rows[i].m});
      nclr = 0;
      hi = 0;
      if (rows[i].p > 0) begin
        ldv <= 16'hBEEF;
        ld <= 1;
        @(posedge clk_sys);
        ld <= 0;
        pulse(rows[i].p);
      end else begin
        go(16'h1231);
      end
      flag(rows[i].f);
      rdv;
      chk("value", v, (rows[i].p > 0 && rows[i].f) ? 16'hBEEF : 16'h1234);
      chk("out", uo, rows[i].o);
      chk("high seen", hi, rows[i].h);
      chk("timer clear", nclr, rows[i].c);
      if (rows[i].p == 0) chk("pad", {pin_o, oe_n}, {rows[i].o, 1'b0});
    end
    // refused accesses
    wr(8'h14, 8'hFF);
    rd(8'h14);
    chk("unmapped", rdat, 32'h0);
    wb(1, `CCU_OFF_CAPSEL, 32'h3, 4'hE);
    rd(`CCU_OFF_CAPSEL);
    chk("lane off", rdat, 32'h0);
    // sleep: capture only with an external timer clock
    slp <= 1;
    cfg({4'h8, CCU_CAP_RISE});
    pulse(1);
    flag(0);
    ext <= 1;
    pulse(1);
    flag(1);
    wr(`CCU_OFF_IRQ, 8'h02);
    @(posedge clk_sys);
    chk("wake", irq, 1'b1);
    wr(`CCU_OFF_IRQ, 8'h01);
    flag(0);
    slp <= 0;
    ext <= 0;
    // ratio change keeps the rise count already gathered
    cfg({4'h8, CCU_CAP_R4});
    pulse(2);
    wr(`CCU_OFF_CTRL, {4'h8, CCU_CAP_R16});
    wr(`CCU_OFF_IRQ, 8'h01);
    pulse(13);
    flag(0);
    pulse(1);
    flag(1);
    // internal source select ignores the pad
    wr(`CCU_OFF_CAPSEL, 8'h01);
    cfg({4'h8, CCU_CAP_RISE});
    pulse(1);
    flag(0);
    src <= 3'h1;
    repeat (4) @(posedge clk_sys);
    flag(1);
    src <= 3'h0;
    wr(`CCU_OFF_CAPSEL, 8'h00);
    // open drain releases a high output; zero control forces it low
    wr(`CCU_OFF_VALL, 8'h34);
    wr(`CCU_OFF_VALH, 8'h12);
    cfg({4'h9, CCU_CMP_SET});
    go(16'h1231);
    chk("drain pad", {uo, pin_o, oe_n}, 3'b101);
    wr(`CCU_OFF_CTRL, 8'h00);
    chk("zero ctrl", uo, 1'b0);
    // a match reached while the timer is stopped in sleep is lost
    slp <= 1;
    cfg({4'h8, CCU_CMP_SET});
    ldv <= 16'h1234;
    ld <= 1;
    @(posedge clk_sys);
    ld <= 0;
    repeat (2) @(posedge clk_sys);
    slp <= 0;
    flag(0);
    chk("sleep out", uo, 1'b0);
    // pwm codes only claim the pad; an input direction releases it
    cfg({4'h8, CCU_PWM0});
    chk("pwm pad", {pin_o, oe_n}, 2'b00);
    dir <= 1;
    repeat (2) @(posedge clk_sys);
    chk("input pad", oe_n, 1'b1);
    // mid-run reset brings registers and pins back to idle
    dir <= 0;
    rst <= 1;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    chk("rerun pins", {ack, uo, tclr, irq, oe_n}, 5'b00001);
    rd(`CCU_OFF_CTRL);
    chk("rerun ctrl", rdat, 32'h0);
    wrap_up;
  end
endmodule
